// >>> css_pkg.sv
// constants and types for the charge state sequencer
package css_pkg;

  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned TIMER_BITS     = 14;
  localparam int unsigned SLOW_DIV       = 50000;
  localparam int unsigned SYNC_STAGES    = 2;

  // -----------------------------------------------------------------
  // wishbone register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h0c;
  localparam logic [7:0] ADDR_TIMER      = 8'h10;
  localparam logic [7:0] ADDR_CTRL       = 8'h14;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int unsigned ST_CODE_LSB    = 0;
  localparam int unsigned ST_SHUT_BIT    = 2;
  localparam int unsigned ST_IDLE_BIT    = 3;
  localparam int unsigned ST_OSC_BIT     = 4;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_START      = 0;
  localparam int unsigned IRQ_BULK       = 1;
  localparam int unsigned IRQ_OVER       = 2;
  localparam int unsigned IRQ_TOPOFF_DONE = 3;
  localparam int unsigned CTRL_ABORT_BIT = 0;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0]       CODE_RST   = 2'h0;

  // -----------------------------------------------------------------
  // charge states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSS_IDLE     = 3'b000,
    CSS_TRICKLE  = 3'b001,
    CSS_BULK     = 3'b010,
    CSS_OVER     = 3'b011,
    CSS_TOPOFF   = 3'b100,
    CSS_SHUTDOWN = 3'b101
  } css_state_t;

  localparam logic [1:0] CODE_TRICKLE = 2'b00;
  localparam logic [1:0] CODE_BULK    = 2'b01;
  localparam logic [1:0] CODE_OVER    = 2'b10;
  localparam logic [1:0] CODE_TOPOFF  = 2'b11;

endpackage

// >>> css_sync.sv
// two-stage level synchroniser
module css_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> css_timer.sv
// slow oscillator tick and overcharge counter
module css_timer #(
  parameter int unsigned DIV  = css_pkg::SLOW_DIV,
  parameter int unsigned BITS = css_pkg::TIMER_BITS
) (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // control
  input  wire logic            run,
  input  wire logic            clear,
  // status
  output logic                 osc_tick,
  output logic      [BITS-1:0] count,
  output logic                 expired
);

  localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] div_reg;

  // ---------------------------------------------------------------
  // slow oscillator, stopped unless run
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= '0;
      osc_tick <= 1'b0;
    end else if (clear || !run) begin
      div_reg  <= '0;
      osc_tick <= 1'b0;
    end else if (div_reg == DIV_LAST) begin
      div_reg  <= '0;
      osc_tick <= 1'b1;
    end else begin
      div_reg  <= div_reg + 1'b1;
      osc_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // counter; expires when it wraps past all ones
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (clear) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (run && osc_tick && !expired) begin
      count   <= count + 1'b1;
      expired <= &count;
    end
  end

endmodule

// >>> css_top.sv
// charge state sequencer with wishbone status and interrupt registers

// Notes on behaviour
// R1 - A charge cycle starts only on a rising edge of the charge start pin and then steps through the states in order.
// R2 - The state code reads 00 trickle, 01 bulk, 10 overcharge, 11 top-off on bit1,bit0.
// R3 - Trickle charge holds while the trickle comparator says the battery is below its threshold.
// R4 - Once the trickle threshold is met the sequencer moves from trickle to bulk.
// R5 - A battery already above the trickle threshold at start goes straight to bulk.
// R6 - Bulk ends and overcharge begins when the voltage comparator sees 95 percent of the reference reached.
// R7 - The slow timer oscillator runs only in the overcharge states.
// R8 - In trickle the voltage loop output is disabled to high impedance.
// R9 - In bulk both the voltage loop and the current loop are enabled.
// R10 - In overcharge, current above the taper threshold moves to top-off with both code bits high.
// R11 - When the 14-bit overcharge timer expires the sequencer shuts down and pulls the start pin low.
// R12 - After shutdown a fresh rising edge on the start pin clears the timer and restarts charging.
// R13 - Every comparator input and the start pin are synchronised before use.
module css_top #(
  parameter int unsigned SLOW_DIV   = css_pkg::SLOW_DIV,
  parameter int unsigned TIMER_BITS = css_pkg::TIMER_BITS
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // comparator results
  input  wire logic        trickle_threshold_met,
  input  wire logic        battery_at_95pct,
  input  wire logic        current_above_taper,
  // charge start pin, open drain pull-down
  input  wire logic        charge_start_pin_i,
  output logic             charge_start_pin_o,
  output logic             charge_start_pin_oe,
  // state code, open drain
  output logic             state_code_bit0_o,
  output logic             state_code_bit0_oe,
  output logic             state_code_bit1_o,
  output logic             state_code_bit1_oe,
  // analog loop controls
  output logic             volt_loop_hiz,
  output logic             volt_loop_en,
  output logic             curr_loop_en,
  output logic             trickle_current_en,
  output logic             slow_osc_run,
  // interrupt
  output logic             irq
);

  // -----------------------------------------------------------------
  // input synchronisation
  // -----------------------------------------------------------------
  logic [3:0] sync_q;
  logic       start_s;
  logic       trk_ok_s;
  logic       v95_s;
  logic       taper_s;

  css_sync #(.WIDTH(4)) u_sync ( // R13
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({charge_start_pin_i, trickle_threshold_met,
                battery_at_95pct, current_above_taper}),
    .sync_out (sync_q)
  );

  assign start_s  = sync_q[3];
  assign trk_ok_s = sync_q[2];
  assign v95_s    = sync_q[1];
  assign taper_s  = sync_q[0];

  logic [1:0] warm_reg;
  logic       start_d_reg;
  logic       start_rise;

  // no edge until the synchroniser has filled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_reg <= 2'h0;
    end else begin
      warm_reg <= {warm_reg[0], 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_d_reg <= 1'b1;
    end else begin
      start_d_reg <= warm_reg[1] ? start_s : 1'b1;
    end
  end

  assign start_rise = start_s && !start_d_reg; // R1

  // -----------------------------------------------------------------
  // timer
  // -----------------------------------------------------------------
  css_pkg::css_state_t state_reg;
  css_pkg::css_state_t state_next;
  logic                  timer_run;
  logic                  timer_clear;
  logic                  timer_exp;
  logic [TIMER_BITS-1:0] timer_cnt;
  logic                  abort_reg;

  assign timer_run   = (state_reg == css_pkg::CSS_OVER) ||
                       (state_reg == css_pkg::CSS_TOPOFF); // R7
  assign timer_clear = start_rise || abort_reg; // R12

  css_timer #(
    .DIV  (SLOW_DIV),
    .BITS (TIMER_BITS)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (timer_run),
    .clear    (timer_clear),
    .osc_tick (),
    .count    (timer_cnt),
    .expired  (timer_exp)
  );

  // -----------------------------------------------------------------
  // state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      css_pkg::CSS_IDLE,
      css_pkg::CSS_SHUTDOWN: begin
        if (start_rise) begin // R1 R12
          state_next = trk_ok_s ? css_pkg::CSS_BULK : css_pkg::CSS_TRICKLE; // R5
        end
      end
      css_pkg::CSS_TRICKLE: begin
        if (trk_ok_s) begin // R3 R4
          state_next = css_pkg::CSS_BULK;
        end
      end
      css_pkg::CSS_BULK: begin
        if (v95_s) begin // R6
          state_next = css_pkg::CSS_OVER;
        end
      end
      css_pkg::CSS_OVER: begin
        if (timer_exp) begin // R11
          state_next = css_pkg::CSS_SHUTDOWN;
        end else if (taper_s) begin // R10
          state_next = css_pkg::CSS_TOPOFF;
        end
      end
      css_pkg::CSS_TOPOFF: begin
        if (timer_exp) begin // R11
          state_next = css_pkg::CSS_SHUTDOWN;
        end
      end
      default: begin
        state_next = css_pkg::CSS_IDLE;
      end
    endcase
    if (abort_reg) begin
      state_next = css_pkg::CSS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= css_pkg::CSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------
  // registered outputs decoded from next state
  // -----------------------------------------------------------------
  logic [1:0] code_next;

  always_comb begin
    case (state_next)
      css_pkg::CSS_BULK:   code_next = css_pkg::CODE_BULK;
      css_pkg::CSS_OVER:   code_next = css_pkg::CODE_OVER;
      css_pkg::CSS_TOPOFF: code_next = css_pkg::CODE_TOPOFF;
      default:             code_next = css_pkg::CODE_TRICKLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_code_bit0_o   <= 1'b0;
      state_code_bit0_oe  <= 1'b1;
      state_code_bit1_o   <= 1'b0;
      state_code_bit1_oe  <= 1'b1;
      volt_loop_hiz       <= 1'b0;
      volt_loop_en        <= 1'b0;
      curr_loop_en        <= 1'b0;
      trickle_current_en  <= 1'b0;
      slow_osc_run        <= 1'b0;
      charge_start_pin_o  <= 1'b0;
      charge_start_pin_oe <= 1'b0;
    end else begin
      // open drain: drive low for a zero bit, release for a one
      state_code_bit0_o   <= 1'b0;
      state_code_bit0_oe  <= !code_next[0]; // R2
      state_code_bit1_o   <= 1'b0;
      state_code_bit1_oe  <= !code_next[1]; // R2
      volt_loop_hiz       <= (state_next == css_pkg::CSS_TRICKLE); // R8
      trickle_current_en  <= (state_next == css_pkg::CSS_TRICKLE);
      volt_loop_en        <= (state_next == css_pkg::CSS_BULK) ||
                             (state_next == css_pkg::CSS_OVER) ||
                             (state_next == css_pkg::CSS_TOPOFF); // R9
      curr_loop_en        <= (state_next == css_pkg::CSS_BULK) ||
                             (state_next == css_pkg::CSS_OVER) ||
                             (state_next == css_pkg::CSS_TOPOFF); // R9
      slow_osc_run        <= (state_next == css_pkg::CSS_OVER) ||
                             (state_next == css_pkg::CSS_TOPOFF); // R7
      charge_start_pin_o  <= 1'b0;
      charge_start_pin_oe <= (state_next == css_pkg::CSS_SHUTDOWN); // R11
    end
  end

  // -----------------------------------------------------------------
  // interrupt events
  // -----------------------------------------------------------------
  logic [css_pkg::IRQ_W-1:0] evt;
  logic [css_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [css_pkg::IRQ_W-1:0] irq_en_reg;
  logic [css_pkg::IRQ_W-1:0] irq_clr;
  logic                      wb_req;
  logic                      wb_wr;

  always_comb begin
    evt = '0;
    evt[css_pkg::IRQ_START] = start_rise &&
                              ((state_reg == css_pkg::CSS_IDLE) ||
                               (state_reg == css_pkg::CSS_SHUTDOWN));
    evt[css_pkg::IRQ_BULK]  = (state_next == css_pkg::CSS_BULK) &&
                              (state_reg != css_pkg::CSS_BULK);
    evt[css_pkg::IRQ_OVER]  = (state_next == css_pkg::CSS_OVER) &&
                              (state_reg != css_pkg::CSS_OVER);
    evt[css_pkg::IRQ_TOPOFF_DONE] = (state_next != state_reg) &&
                              ((state_next == css_pkg::CSS_TOPOFF) ||
                               (state_next == css_pkg::CSS_SHUTDOWN));
  end

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign irq_clr = (wb_wr && (wb_adr_i == css_pkg::ADDR_IRQ_CLR)) ?
                   wb_dat_i[css_pkg::IRQ_W-1:0] : '0;

  // set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | evt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= css_pkg::IRQ_EN_RST;
    end else if (wb_wr && (wb_adr_i == css_pkg::ADDR_IRQ_EN)) begin
      irq_en_reg <= wb_dat_i[css_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((irq_stat_reg & ~irq_clr) | evt)) & irq_en_reg);
    end
  end

  // -----------------------------------------------------------------
  // software abort: one-cycle strobe back to idle
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= wb_wr && (wb_adr_i == css_pkg::ADDR_CTRL) &&
                   wb_dat_i[css_pkg::CTRL_ABORT_BIT];
    end
  end

  // -----------------------------------------------------------------
  // wishbone read and ack
  // -----------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      css_pkg::ADDR_STATUS: begin
        rd_data[css_pkg::ST_CODE_LSB +: 2] = {!state_code_bit1_oe, !state_code_bit0_oe};
        rd_data[css_pkg::ST_SHUT_BIT]      = (state_reg == css_pkg::CSS_SHUTDOWN);
        rd_data[css_pkg::ST_IDLE_BIT]      = (state_reg == css_pkg::CSS_IDLE);
        rd_data[css_pkg::ST_OSC_BIT]       = slow_osc_run;
      end
      css_pkg::ADDR_IRQ_STAT: rd_data[css_pkg::IRQ_W-1:0] = irq_stat_reg;
      css_pkg::ADDR_IRQ_EN:   rd_data[css_pkg::IRQ_W-1:0] = irq_en_reg;
      css_pkg::ADDR_TIMER:    rd_data[TIMER_BITS-1:0]     = timer_cnt;
      default:                rd_data = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : '0;
    end
  end

endmodule

// >>> css_top_sva.sv
// assertion checker for the charge state sequencer ports
module css_top_sva #(
  parameter int unsigned SLOW_DIV   = css_pkg::SLOW_DIV,
  parameter int unsigned TIMER_BITS = css_pkg::TIMER_BITS
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // comparators and start pin
  input  wire logic trickle_threshold_met,
  input  wire logic battery_at_95pct,
  input  wire logic current_above_taper,
  input  wire logic charge_start_pin_i,
  input  wire logic charge_start_pin_o,
  input  wire logic charge_start_pin_oe,
  // state code and loop controls
  input  wire logic state_code_bit0_oe,
  input  wire logic state_code_bit1_oe,
  input  wire logic state_code_bit0_o,
  input  wire logic state_code_bit1_o,
  input  wire logic volt_loop_hiz,
  input  wire logic volt_loop_en,
  input  wire logic curr_loop_en,
  input  wire logic trickle_current_en,
  input  wire logic slow_osc_run
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HI_CNT = (2 ** TIMER_BITS) * SLOW_DIV + 4;
  localparam int unsigned LO_CNT = (2 ** TIMER_BITS - 1) * SLOW_DIV;
  logic [1:0]  code;
  logic [31:0] osc_cnt;
  assign code = {~state_code_bit1_oe, ~state_code_bit0_oe};
  // cycles spent with the slow oscillator running
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= 32'h0;
    end else begin
      osc_cnt <= slow_osc_run ? osc_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_trickle_out;
    volt_loop_hiz |-> code == 2'b00 && trickle_current_en && !volt_loop_en && !curr_loop_en;
  endproperty
  a_trickle_out: assert property (p_trickle_out) else $error("trickle outputs wrong");
  property p_bulk_out;
    code == 2'b01 |-> volt_loop_en && curr_loop_en && !volt_loop_hiz && !slow_osc_run;
  endproperty
  a_bulk_out: assert property (p_bulk_out) else $error("bulk outputs wrong");
  property p_osc;
    slow_osc_run == code[1];
  endproperty
  a_osc: assert property (p_osc) else $error("slow oscillator outside overcharge");
  property p_stay_trickle;
    (volt_loop_hiz && !trickle_threshold_met) [*3] |=> volt_loop_hiz;
  endproperty
  a_stay_trickle: assert property (p_stay_trickle) else $error("left trickle early");
  property p_leave_trickle;
    volt_loop_hiz && trickle_threshold_met |-> ##[1:4] (volt_loop_en && !volt_loop_hiz);
  endproperty
  a_leave_trickle: assert property (p_leave_trickle) else $error("trickle not left");
  property p_bulk_over;
    code == 2'b01 && battery_at_95pct |-> ##[1:4] code[1];
  endproperty
  a_bulk_over: assert property (p_bulk_over) else $error("overcharge not entered");
  property p_topoff;
    code == 2'b10 && current_above_taper |-> ##[1:4] (code == 2'b11 || charge_start_pin_oe);
  endproperty
  a_topoff: assert property (p_topoff) else $error("top-off not entered");
  property p_shut;
    $rose(charge_start_pin_oe) |-> code == 2'b00 && $past(slow_osc_run) && osc_cnt >= LO_CNT;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown entered wrongly");
  property p_timeout;
    osc_cnt <= HI_CNT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("overcharge timer overran");
  property p_start;
    $rose(volt_loop_en || volt_loop_hiz) |-> $past(charge_start_pin_i, 2);
  endproperty
  a_start: assert property (p_start) else $error("charge began without start edge");
  property p_restart;
    $fell(charge_start_pin_oe) |-> volt_loop_en || volt_loop_hiz;
  endproperty
  a_restart: assert property (p_restart) else $error("shutdown left without restart");
  property p_od_low;
    !charge_start_pin_o && !state_code_bit0_o && !state_code_bit1_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain data not low");
  c_topoff: cover property (code == 2'b10 ##1 code == 2'b11);
  c_shut: cover property ($rose(charge_start_pin_oe));
  c_restart: cover property ($fell(charge_start_pin_oe));
endmodule

bind css_top css_top_sva #(.SLOW_DIV(SLOW_DIV), .TIMER_BITS(TIMER_BITS)) i_sva (
  .sys_clk, .rst_n, .trickle_threshold_met, .battery_at_95pct, .current_above_taper,
  .charge_start_pin_i, .charge_start_pin_oe, .state_code_bit0_oe, .state_code_bit1_oe,
  .volt_loop_hiz, .volt_loop_en, .curr_loop_en, .trickle_current_en, .slow_osc_run,
  .charge_start_pin_o, .state_code_bit0_o, .state_code_bit1_o
);

// >>> css_batt_model.sv
// battery comparators and charge start source model
module css_batt_model #(
  parameter logic [7:0] TRICKLE_LVL = 8'h20,
  parameter logic [7:0] OVER_LVL    = 8'h40,
  parameter logic [7:0] TAPER_LVL   = 8'h48
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       slow,
  input  wire logic       pin_drive,
  // charger current from the device
  input  wire logic       trickle_current_en,
  input  wire logic       curr_loop_en,
  // comparators and pin
  output logic            trickle_threshold_met,
  output logic            battery_at_95pct,
  output logic            current_above_taper,
  output logic            charge_start_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] vbat_reg;
  logic [1:0] div_reg;
  // battery climbs only while current flows, every fourth cycle when slow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vbat_reg <= 8'h00;
    end else if (load) begin
      vbat_reg <= load_val;
    end else if ((trickle_current_en || curr_loop_en) && (!slow || div_reg == 2'h3)
                 && vbat_reg != 8'hff) begin
      vbat_reg <= vbat_reg + 8'h01;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign trickle_threshold_met = vbat_reg >= TRICKLE_LVL;
  assign battery_at_95pct      = vbat_reg >= OVER_LVL;
  assign current_above_taper   = vbat_reg >= TAPER_LVL;
  // source overpowers the weak internal pull-down; released pin sits low
  assign charge_start_pin = pin_drive;
endmodule

// >>> css_top_bench.sv
// self-checking testbench for the charge state sequencer
module css_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] V_TRK = 6'h04, V_BLK = 6'h09, V_OVR = 6'h1a;
  localparam logic [5:0] V_TOP = 6'h1b, V_SHD = 6'h20, V_IDL = 6'h00;
  logic        sys_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, load = 1'b0, slow = 1'b0, pin_drive = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, load_val = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd;
  logic        wb_ack_o, trickle_threshold_met, battery_at_95pct, current_above_taper;
  logic        charge_start_pin, charge_start_pin_oe, state_code_bit0_oe, state_code_bit1_oe;
  logic        volt_loop_hiz, volt_loop_en, curr_loop_en, trickle_current_en, slow_osc_run, irq;
  int          error_cnt = 0, n_checks = 0, seed = 49;
  logic [31:0] rd_q[$];
  logic [5:0]  st_q[$];
  logic [5:0]  st_prev = 6'h00;
  wire  [5:0]  st_now = {charge_start_pin_oe, slow_osc_run, curr_loop_en, volt_loop_hiz,
                         ~state_code_bit1_oe, ~state_code_bit0_oe};
  always #2 sys_clk = ~sys_clk;
  css_top #(.SLOW_DIV(2), .TIMER_BITS(3)) i_dut (
    .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .trickle_threshold_met, .battery_at_95pct, .current_above_taper,
    .charge_start_pin_i(charge_start_pin), .charge_start_pin_o(), .charge_start_pin_oe,
    .state_code_bit0_o(), .state_code_bit0_oe, .state_code_bit1_o(), .state_code_bit1_oe,
    .volt_loop_hiz, .volt_loop_en, .curr_loop_en, .trickle_current_en, .slow_osc_run, .irq);
  css_batt_model i_batt (
    .sys_clk, .rst_n, .load, .load_val, .slow, .pin_drive, .trickle_current_en,
    .curr_loop_en, .trickle_threshold_met, .battery_at_95pct, .current_above_taper,
    .charge_start_pin);
  task automatic report(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    report(got === exp, got, exp);
  endtask
  task automatic cmp_st(input logic [5:0] got, input logic [5:0] exp);
    report(got === exp, {26'h0, got}, {26'h0, exp});
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    report(got === exp, {31'h0, got}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // result watcher: read data on ack, every change of the state outputs
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp_rd(wb_dat_o, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
    if (rst_n && st_now !== st_prev) begin
      cmp_st(st_now, st_q.size() > 0 ? st_q.pop_front() : 'x);
      st_prev = st_now;
    end
  end
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) report(1'b0, 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_cycle(1'b0, adr, 32'h0);
  endtask
  task automatic wait_q(input int left);
    int n;
    n = 0;
    while (st_q.size() > left && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 600) report(1'b0, st_q.size(), left);
  endtask
  task automatic start_pulse;
    pin_drive <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pin_drive <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic load_batt(input logic [7:0] v, input logic s);
    load <= 1'b1;
    load_val <= v;
    slow <= s;
    @(posedge sys_clk);
    load <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(css_pkg::ADDR_IRQ_EN, 32'h0);
    rd(8'h20, 32'h0);
    wb_sel_i <= 4'he;
    wb_cycle(1'b1, css_pkg::ADDR_IRQ_EN, 32'hf);
    wb_sel_i <= 4'hf;
    rd(css_pkg::ADDR_IRQ_EN, 32'h0);
    wb_cycle(1'b1, css_pkg::ADDR_IRQ_EN, 32'hf);
    // full cycle from a deep battery, taper before timer
    load_batt(8'h10, 1'b0);
    st_q = '{V_TRK, V_BLK, V_OVR, V_TOP, V_SHD};
    start_pulse();
    wait_q(0);
    cmp_bit(irq, 1'b1);
    rd(css_pkg::ADDR_IRQ_STAT, 32'hf);
    wb_cycle(1'b1, css_pkg::ADDR_IRQ_CLR, 32'hf);
    rd(css_pkg::ADDR_IRQ_STAT, 32'h0);
    cmp_bit(irq, 1'b0);
    wb_cycle(1'b1, css_pkg::ADDR_IRQ_EN, 32'h0);
    // restart above threshold, timer expires before taper
    load_batt(8'h30, 1'b1);
    st_q = '{V_BLK, V_OVR, V_SHD};
    start_pulse();
    wait_q(0);
    cmp_bit(irq, 1'b0);
    rd(css_pkg::ADDR_IRQ_STAT, 32'hf);
    rd(css_pkg::ADDR_STATUS, 32'h1 << css_pkg::ST_SHUT_BIT);
    // random start level, stray start edge in bulk, abort in overcharge
    rnd = $random(seed);
    load_batt(8'h21 + {4'h0, rnd[3:1], 1'b0}, 1'b1);
    st_q = '{V_BLK};
    start_pulse();
    wait_q(0);
    st_q = '{V_OVR, V_IDL};
    start_pulse();
    wait_q(1);
    wb_cycle(1'b1, css_pkg::ADDR_CTRL, 32'h1);
    wait_q(0);
    rd(css_pkg::ADDR_STATUS, 32'h1 << css_pkg::ST_IDLE_BIT);
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
